// ---- fcs_pkg.sv ----
// Shared constants for the flash configuration and status register block.
package fcs_pkg;

  // Register word addresses on the parallel memory bus.
  localparam logic [15:0] FCS_ADDR_CONFIG       = 16'hf221;
  localparam logic [15:0] FCS_ADDR_CONFIG_SPARE = 16'hf222;
  localparam logic [15:0] FCS_ADDR_STATUS       = 16'hf240;

  // Reset values.
  localparam logic [15:0] FCS_CONFIG_RESET = 16'h40c0;
  localparam logic [15:0] FCS_STATUS_RESET = 16'h0000;

  // Configuration field positions.
  localparam int FCS_CFG_READ_SYNC_BIT   = 15;
  localparam int FCS_CFG_LATENCY_LSB     = 12;
  localparam int FCS_CFG_BURST_LSB       = 9;
  localparam int FCS_CFG_ECC_BYPASS_BIT  = 8;
  localparam int FCS_CFG_READY_POL_BIT   = 7;
  localparam int FCS_CFG_IRQ_POL_BIT     = 6;
  localparam int FCS_CFG_DRIVER_EN_BIT   = 5;
  localparam int FCS_CFG_READY_WITH_BIT  = 4;
  localparam int FCS_CFG_BOOT_PROT_BIT   = 0;

  // Status field positions.
  localparam int FCS_ST_ONGOING_BIT = 15;
  localparam int FCS_ST_LOCK_BIT    = 14;
  localparam int FCS_ST_LOAD_BIT    = 13;
  localparam int FCS_ST_PROG_BIT    = 12;
  localparam int FCS_ST_ERASE_BIT   = 11;
  localparam int FCS_ST_ERROR_BIT   = 10;
  localparam int FCS_ST_SUSPEND_BIT = 9;
  localparam int FCS_ST_RESET_BIT   = 7;
  localparam int FCS_ST_OTP_BIT     = 6;
  localparam int FCS_ST_EXPIRY_BIT  = 0;

  // Latency codes: lowest supported code and reset code.
  localparam logic [2:0] FCS_LATENCY_MIN_CODE   = 3'h3;
  localparam logic [2:0] FCS_LATENCY_RESET_CODE = 3'h4;

  // Burst size codes.
  localparam logic [2:0] FCS_BURST_CONT  = 3'h0;
  localparam logic [2:0] FCS_BURST_4     = 3'h1;
  localparam logic [2:0] FCS_BURST_8     = 3'h2;
  localparam logic [2:0] FCS_BURST_16    = 3'h3;
  localparam logic [5:0] FCS_WORDS_CONT  = 6'h00;
  localparam logic [5:0] FCS_WORDS_4     = 6'h04;
  localparam logic [5:0] FCS_WORDS_8     = 6'h08;
  localparam logic [5:0] FCS_WORDS_16    = 6'h10;

  // Operation kinds reported by the flash engine.
  typedef enum logic [1:0] {
    FCS_OP_LOAD  = 2'h0,
    FCS_OP_PROG  = 2'h1,
    FCS_OP_ERASE = 2'h2,
    FCS_OP_OTHER = 2'h3
  } fcs_op_t;

  // Engine phase as seen by the status word, Gray coded along the usual path.
  typedef enum logic [1:0] {
    FCS_PH_READY = 2'b00,
    FCS_PH_BUSY  = 2'b01,
    FCS_PH_RESET = 2'b11
  } fcs_phase_t;

endpackage

// ---- fcs_regs.sv ----
// Configuration and status registers of the flash host interface.
`timescale 1ns/100ps
// How it works
// - Config bit 15 selects asynchronous (0, default) or synchronous clocked reads.
// - Latency bits 14:12 give 3..7 cycles; codes 000..010 unsupported; 4 default.
// - Burst bits 11:9: continuous, 4, 8, 16 words; 100..111 unavailable.
// - The same burst size serves wrap-around and linear bursts.
// - Bit 8 low corrects errors, bit 8 high bypasses correction.
// - Bit 7 high: ready pin high means ready; low: low means ready.
// - Bit 6 high: irq pin follows master interrupt bit; low: inverted.
// - Irq and ready pins stay undriven until the driver enable is set.
// - Pin polarity settings show on the pins only with driver enable set.
// - Driver enable clears on cold reset or a host write of zero.
// - Bit 4 low: ready one clock before data; high: ready with data.
// - Config bit 0 reads as fixed zero, boot buffer locked.
// - Config register resets to 40C0h.
// - Status bit 15 is set while any internal operation runs.
// - Status bit 14 flags an access that hit a locked area.
// - Status bits 13,12,11 show load, program, erase busy or failed.
// - Status bit 10 flags failure, abort by reset or invalid command.
// - Status bit 9 shows erase suspended, through suspended activity.
// - Status word is read-only, resets to 0000h, reserved bits read zero.
// - Status bit 7 is set while a reset operation is in progress.
// - Status bit 6 reports the one-time area lock, caught at power-on.
// - Status bit 0, the expiry flag, is always zero.
module fcs_regs (
  input  wire logic           ref_clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           warm_reset_i,
  input  wire logic [15:0]    reg_addr_i,
  input  wire logic [15:0]    reg_wdata_i,
  input  wire logic           reg_wr_i,
  input  wire logic           reg_rd_i,
  output logic      [15:0]    reg_rdata_o,
  input  wire logic           op_start_i,
  input  wire fcs_pkg::fcs_op_t op_kind_i,
  input  wire logic           op_done_i,
  input  wire logic           op_fail_i,
  input  wire logic           op_lock_hit_i,
  input  wire logic           invalid_cmd_i,
  input  wire logic           erase_suspend_i,
  input  wire logic           erase_resume_i,
  input  wire logic           reset_op_start_i,
  input  wire logic           reset_op_done_i,
  input  wire logic           onetime_lock_i,
  input  wire logic           irq_master_i,
  input  wire logic           burst_data_next_i,
  input  wire logic           burst_data_after_next_i,
  output logic                read_timing_select_o,
  output logic      [2:0]     burst_first_latency_o,
  output logic      [5:0]     burst_words_o,
  output logic                ecc_bypass_o,
  output logic                ready_pin_o,
  output logic                ready_pin_oe_o,
  output logic                irq_pin_o,
  output logic                irq_pin_oe_o
);
  import fcs_pkg::*;

  // Configuration fields, each held in its own flip-flops.
  logic       read_timing_select_reg;
  logic [2:0] burst_first_latency_reg;
  logic [2:0] burst_size_reg;
  logic       ecc_bypass_reg;
  logic       ready_pin_polarity_reg;
  logic       irq_pin_polarity_reg;
  logic       irq_ready_driver_enable_reg;
  logic       ready_with_data_reg;

  // Status word pieces.
  fcs_phase_t phase_reg;
  logic       lock_reg;
  logic       load_reg;
  logic       prog_reg;
  logic       erase_reg;
  logic       error_reg;
  logic       suspend_reg;
  logic       onetime_area_lock_flag_reg;
  logic       otp_capture_pending_reg;

  // Pin and read-data registers.
  logic [15:0] rdata_reg;
  logic [5:0]  burst_words_reg;
  logic        ready_pin_reg;
  logic        irq_pin_reg;
  logic        pins_oe_reg;

  // Decoded accesses and assembled words.
  logic        cfg_write;
  logic [15:0] config_word;
  logic [15:0] status_word;
  logic [2:0]  wr_latency;
  logic [2:0]  wr_burst;
  logic        ready_active;
  logic        ready_level_next;

  assign cfg_write  = reg_wr_i && (reg_addr_i == FCS_ADDR_CONFIG);
  assign wr_latency = reg_wdata_i[FCS_CFG_LATENCY_LSB +: 3];
  assign wr_burst   = reg_wdata_i[FCS_CFG_BURST_LSB +: 3];

  // Read mode. A warm or hot reset restores it as the cold one does.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      read_timing_select_reg <= FCS_CONFIG_RESET[FCS_CFG_READ_SYNC_BIT];
    end else if (cfg_write) begin
      read_timing_select_reg <= reg_wdata_i[FCS_CFG_READ_SYNC_BIT];
    end
  end

  // Burst latency. Unsupported codes would stall the burst engine forever,
  // so such a write leaves the previous latency in place.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      burst_first_latency_reg <= FCS_CONFIG_RESET[FCS_CFG_LATENCY_LSB +: 3];
    end else if (cfg_write && (wr_latency >= FCS_LATENCY_MIN_CODE)) begin
      burst_first_latency_reg <= wr_latency;
    end
  end

  // Burst size. The unavailable and reserved codes are refused the same way.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      burst_size_reg <= FCS_CONFIG_RESET[FCS_CFG_BURST_LSB +: 3];
    end else if (cfg_write && (wr_burst <= FCS_BURST_16)) begin
      burst_size_reg <= wr_burst;
    end
  end

  // Error correction bypass and the pin options.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      ecc_bypass_reg         <= FCS_CONFIG_RESET[FCS_CFG_ECC_BYPASS_BIT];
      ready_pin_polarity_reg <= FCS_CONFIG_RESET[FCS_CFG_READY_POL_BIT];
      irq_pin_polarity_reg   <= FCS_CONFIG_RESET[FCS_CFG_IRQ_POL_BIT];
      ready_with_data_reg    <= FCS_CONFIG_RESET[FCS_CFG_READY_WITH_BIT];
    end else if (cfg_write) begin
      ecc_bypass_reg         <= reg_wdata_i[FCS_CFG_ECC_BYPASS_BIT];
      ready_pin_polarity_reg <= reg_wdata_i[FCS_CFG_READY_POL_BIT];
      irq_pin_polarity_reg   <= reg_wdata_i[FCS_CFG_IRQ_POL_BIT];
      ready_with_data_reg    <= reg_wdata_i[FCS_CFG_READY_WITH_BIT];
    end
  end

  // Driver enable survives a warm or hot reset; only the cold reset or a
  // host write of zero takes it down.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      irq_ready_driver_enable_reg <= FCS_CONFIG_RESET[FCS_CFG_DRIVER_EN_BIT];
    end else if (cfg_write) begin
      irq_ready_driver_enable_reg <= reg_wdata_i[FCS_CFG_DRIVER_EN_BIT];
    end
  end

  // Assembled configuration word; bits 3:1 and bit 0 are constant zero.
  always_comb begin
    config_word = 16'h0000;
    config_word[FCS_CFG_READ_SYNC_BIT]         = read_timing_select_reg;
    config_word[FCS_CFG_LATENCY_LSB +: 3]      = burst_first_latency_reg;
    config_word[FCS_CFG_BURST_LSB +: 3]        = burst_size_reg;
    config_word[FCS_CFG_ECC_BYPASS_BIT]        = ecc_bypass_reg;
    config_word[FCS_CFG_READY_POL_BIT]         = ready_pin_polarity_reg;
    config_word[FCS_CFG_IRQ_POL_BIT]           = irq_pin_polarity_reg;
    config_word[FCS_CFG_DRIVER_EN_BIT]         = irq_ready_driver_enable_reg;
    config_word[FCS_CFG_READY_WITH_BIT]        = ready_with_data_reg;
    config_word[FCS_CFG_BOOT_PROT_BIT]         = 1'b0;
  end

  // Engine phase. A reset operation while busy aborts the running job.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      phase_reg <= FCS_PH_READY;
    end else begin
      unique case (phase_reg)
        FCS_PH_READY: begin
          if (reset_op_start_i) begin
            phase_reg <= FCS_PH_RESET;
          end else if (op_start_i) begin
            phase_reg <= FCS_PH_BUSY;
          end
        end
        FCS_PH_BUSY: begin
          if (reset_op_start_i) begin
            phase_reg <= FCS_PH_RESET;
          end else if (op_done_i) begin
            phase_reg <= FCS_PH_READY;
          end
        end
        FCS_PH_RESET: begin
          if (reset_op_done_i) begin
            phase_reg <= FCS_PH_READY;
          end
        end
        default: begin
          phase_reg <= FCS_PH_READY;
        end
      endcase
    end
  end

  // Operation kind bits. They stay set after a failure so software can see
  // which job failed; a pass clears them. The erase bit also stays set while
  // the erase is suspended, under a nested load or program.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      load_reg  <= 1'b0;
      prog_reg  <= 1'b0;
      erase_reg <= 1'b0;
    end else if (op_start_i && (phase_reg == FCS_PH_READY) && !reset_op_start_i) begin
      load_reg  <= (op_kind_i == FCS_OP_LOAD);
      prog_reg  <= (op_kind_i == FCS_OP_PROG);
      erase_reg <= (op_kind_i == FCS_OP_ERASE) || suspend_reg;
    end else if (op_done_i && (phase_reg == FCS_PH_BUSY) && !op_fail_i) begin
      load_reg  <= 1'b0;
      prog_reg  <= 1'b0;
      erase_reg <= suspend_reg || erase_suspend_i;
    end else if (invalid_cmd_i && (phase_reg == FCS_PH_READY)) begin
      load_reg  <= 1'b0;
      prog_reg  <= 1'b0;
      erase_reg <= suspend_reg;
    end
  end

  // Error and lock flags. A failure, an abort or an invalid command sets the
  // error; it is cleared by a warm reset, when a new job starts or when one passes. Setting
  // takes priority over clearing in the same cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      error_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end else if ((phase_reg == FCS_PH_BUSY) && reset_op_start_i) begin
      error_reg <= 1'b1;
      lock_reg  <= 1'b0;
    end else if (op_done_i && (phase_reg == FCS_PH_BUSY)) begin
      error_reg <= op_fail_i || invalid_cmd_i;
      lock_reg  <= op_fail_i && op_lock_hit_i;
    end else if (invalid_cmd_i) begin
      error_reg <= 1'b1;
      lock_reg  <= 1'b0;
    end else if (warm_reset_i) begin
      error_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end else if (op_start_i && (phase_reg == FCS_PH_READY)) begin
      error_reg <= 1'b0;
      lock_reg  <= 1'b0;
    end
  end

  // Erase suspend flag; a suspend request wins over a resume in one cycle.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      suspend_reg <= 1'b0;
    end else if (erase_suspend_i) begin
      suspend_reg <= 1'b1;
    end else if (erase_resume_i) begin
      suspend_reg <= 1'b0;
    end
  end

  // The one-time area lock is caught once, on the first edge after the
  // cold reset is released, since a reset flop may take only a constant.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      otp_capture_pending_reg    <= 1'b1;
      onetime_area_lock_flag_reg <= 1'b0;
    end else if (otp_capture_pending_reg) begin
      otp_capture_pending_reg    <= 1'b0;
      onetime_area_lock_flag_reg <= onetime_lock_i;
    end
  end

  // Assembled status word; reserved bits and the expiry flag stay zero.
  always_comb begin
    status_word = FCS_STATUS_RESET;
    status_word[FCS_ST_ONGOING_BIT] = (phase_reg != FCS_PH_READY);
    status_word[FCS_ST_LOCK_BIT]    = lock_reg;
    status_word[FCS_ST_LOAD_BIT]    = load_reg;
    status_word[FCS_ST_PROG_BIT]    = prog_reg;
    status_word[FCS_ST_ERASE_BIT]   = erase_reg;
    status_word[FCS_ST_ERROR_BIT]   = error_reg;
    status_word[FCS_ST_SUSPEND_BIT] = suspend_reg;
    status_word[FCS_ST_RESET_BIT]   = (phase_reg == FCS_PH_RESET);
    status_word[FCS_ST_OTP_BIT]     = onetime_area_lock_flag_reg;
    status_word[FCS_ST_EXPIRY_BIT]  = 1'b0;
  end

  // Read data stand for exactly the cycle after the read strobe, zero
  // otherwise; the spare and unmapped addresses read as zero.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_reg <= 16'h0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        FCS_ADDR_CONFIG: begin
          rdata_reg <= config_word;
        end
        FCS_ADDR_STATUS: begin
          rdata_reg <= status_word;
        end
        default: begin
          rdata_reg <= 16'h0000;
        end
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // Burst size in words, for the wrap and the linear burst engines alike.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      burst_words_reg <= FCS_WORDS_CONT;
    end else begin
      unique case (burst_size_reg)
        FCS_BURST_4:  burst_words_reg <= FCS_WORDS_4;
        FCS_BURST_8:  burst_words_reg <= FCS_WORDS_8;
        FCS_BURST_16: burst_words_reg <= FCS_WORDS_16;
        default:      burst_words_reg <= FCS_WORDS_CONT;
      endcase
    end
  end

  // Ready timing. The pin is registered, so the data hints are taken one
  // cycle early: the "after next" hint gives ready one clock before data.
  always_comb begin
    if (read_timing_select_reg) begin
      ready_active = ready_with_data_reg ? burst_data_next_i : burst_data_after_next_i;
    end else begin
      ready_active = (phase_reg == FCS_PH_READY);
    end
    ready_level_next = ready_pin_polarity_reg ? ready_active : !ready_active;
  end

  // Pin drivers. While disabled the pins float and their levels are held
  // low, so no polarity setting is visible before the enable.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      pins_oe_reg   <= 1'b0;
      ready_pin_reg <= 1'b0;
      irq_pin_reg   <= 1'b0;
    end else begin
      pins_oe_reg   <= irq_ready_driver_enable_reg;
      ready_pin_reg <= irq_ready_driver_enable_reg && ready_level_next;
      irq_pin_reg   <= irq_ready_driver_enable_reg &&
                       (irq_pin_polarity_reg ? irq_master_i : !irq_master_i);
    end
  end

  assign reg_rdata_o           = rdata_reg;
  assign read_timing_select_o  = read_timing_select_reg;
  assign burst_first_latency_o = burst_first_latency_reg;
  assign burst_words_o         = burst_words_reg;
  assign ecc_bypass_o          = ecc_bypass_reg;
  assign ready_pin_o           = ready_pin_reg;
  assign ready_pin_oe_o        = pins_oe_reg;
  assign irq_pin_o             = irq_pin_reg;
  assign irq_pin_oe_o          = pins_oe_reg;

endmodule // fcs_regs

// ---- fcs_regs_sva.sv ----
// Bound property checker for the flash configuration and status registers.
`timescale 1ns/100ps
module fcs_regs_sva
  import fcs_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        warm_reset_i,
  input  wire logic [15:0] reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_rdata_o,
  input  wire logic        irq_master_i,
  input  wire logic        read_timing_select_o,
  input  wire logic [2:0]  burst_first_latency_o,
  input  wire logic [5:0]  burst_words_o,
  input  wire logic        ecc_bypass_o,
  input  wire logic        ready_pin_o,
  input  wire logic        ready_pin_oe_o,
  input  wire logic        irq_pin_o,
  input  wire logic        irq_pin_oe_o
);
  logic [15:0] wd_reg;
  logic [15:0] wd2_reg;
  logic [1:0]  pol_reg;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);

  // Delayed write data, so a consequent can name the word that was written.
  always_ff @(posedge ref_clk_i) begin
    wd_reg  <= reg_wdata_i;
    wd2_reg <= wd_reg;
  end

  // Polarity shadow; both resets restore it, since warm reset keeps only the enable.
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i || warm_reset_i) begin
      pol_reg <= 2'h3;
    end else if (reg_wr_i && reg_addr_i == FCS_ADDR_CONFIG) begin
      pol_reg <= reg_wdata_i[7:6];
    end
  end

  sequence cfg_wr;
    reg_wr_i && reg_addr_i == FCS_ADDR_CONFIG;
  endsequence
  sequence cfg_rd;
    reg_rd_i && reg_addr_i == FCS_ADDR_CONFIG;
  endsequence
  sequence st_rd;
    reg_rd_i && reg_addr_i == FCS_ADDR_STATUS;
  endsequence

  a_read_mode: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr |=> read_timing_select_o == wd_reg[15])
    else $error("read mode output does not follow the write");
  a_latency_take: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr ##0 (reg_wdata_i[14:12] >= 3'h3) |=> burst_first_latency_o == wd_reg[14:12])
    else $error("supported latency code not applied");
  a_latency_keep: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr ##0 (reg_wdata_i[14:12] < 3'h3) |=> $stable(burst_first_latency_o))
    else $error("unsupported latency code changed the latency");
  a_burst_words: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr ##0 (reg_wdata_i[11:9] <= 3'h3) |-> ##2
    burst_words_o == ((wd2_reg[11:9] == 3'h0) ? 6'h00 : (6'h02 << wd2_reg[11:9])))
    else $error("burst word count wrong");
  a_ecc_bypass: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr |=> ecc_bypass_o == wd_reg[8])
    else $error("correction bypass does not follow the write");
  a_driver_enable: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_wr |-> ##2 ready_pin_oe_o == wd2_reg[5] && irq_pin_oe_o == wd2_reg[5])
    else $error("pin drivers do not follow the enable bit");
  a_pins_quiet: assert property (!ready_pin_oe_o |-> !ready_pin_o && !irq_pin_o)
    else $error("pin level moves while drivers are off");
  a_irq_level: assert property (irq_pin_oe_o && $past(irq_pin_oe_o) &&
    $stable(irq_master_i) && $stable(pol_reg) |-> irq_pin_o == (irq_master_i ~^ pol_reg[0]))
    else $error("interrupt pin level wrong for polarity");
  a_cfg_readback: assert property (disable iff (!reset_n_i || warm_reset_i)
    cfg_rd |=> reg_rdata_o[3:0] == 4'h0 && reg_rdata_o[15] == read_timing_select_o &&
    reg_rdata_o[14:12] == burst_first_latency_o)
    else $error("configuration read back wrong");
  a_status_fixed: assert property (st_rd |=> (reg_rdata_o & 16'h013f) == 16'h0000)
    else $error("fixed status bits not zero");
  a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 16'h0000)
    else $error("read data outside its cycle");
endmodule // fcs_regs_sva

bind fcs_regs fcs_regs_sva u_sva (
  .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .warm_reset_i(warm_reset_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .irq_master_i(irq_master_i),
  .read_timing_select_o(read_timing_select_o), .burst_first_latency_o(burst_first_latency_o),
  .burst_words_o(burst_words_o), .ecc_bypass_o(ecc_bypass_o), .ready_pin_o(ready_pin_o),
  .ready_pin_oe_o(ready_pin_oe_o), .irq_pin_o(irq_pin_o), .irq_pin_oe_o(irq_pin_oe_o));

// ---- fcs_host_model.sv ----
// Host bus master model that reaches the registers over the plain register port.
`timescale 1ns/100ps
module fcs_host_model (
  input  wire logic        ref_clk_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic      [15:0] reg_addr_o,
  output logic      [15:0] reg_wdata_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o
);
  // Idle bus from time zero, so the port never sees unknown strobes.
  initial begin
    reg_addr_o  = 16'h0000;
    reg_wdata_o = 16'h0000;
    reg_wr_o    = 1'b0;
    reg_rd_o    = 1'b0;
  end

  // One-cycle write; data is inverted afterwards so stale data never looks valid.
  task automatic write(input logic [15:0] addr, input logic [15:0] data);
    @(posedge ref_clk_i);
    reg_addr_o  <= addr;
    reg_wdata_o <= data;
    reg_wr_o    <= 1'b1;
    @(posedge ref_clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~data;
  endtask

  // Read data is taken at the edge closing the one cycle in which it stands.
  task automatic read(input logic [15:0] addr, output logic [15:0] data);
    @(posedge ref_clk_i);
    reg_addr_o <= addr;
    reg_rd_o   <= 1'b1;
    @(posedge ref_clk_i);
    reg_rd_o   <= 1'b0;
    @(posedge ref_clk_i);
    data = reg_rdata_i;
  endtask
endmodule // fcs_host_model

// ---- fcs_regs_tb.sv ----
// Self-checking testbench for the flash configuration and status registers.
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, exp, got); end end
module fcs_regs_tb;
  import fcs_pkg::*;
  localparam logic [8:0] START = 9'h100, DONE = 9'h080, FAIL = 9'h040, LOCK = 9'h020;
  localparam logic [8:0] INV = 9'h010, SUSP = 9'h008, RES = 9'h004, RST = 9'h002;
  localparam logic [8:0] RSTD = 9'h001;
  localparam logic [15:0] CFG = FCS_ADDR_CONFIG, ST = FCS_ADDR_STATUS;
  localparam logic [5:0] WORDS [4] = '{FCS_WORDS_CONT, FCS_WORDS_4, FCS_WORDS_8, FCS_WORDS_16};
  logic        ref_clk_i, reset_n_i, warm_reset_i, onetime_lock_i, irq_master_i;
  logic [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rd, cw, sb;
  logic        reg_wr_i, reg_rd_i, rts, ecc, rdy, rdy_oe, irq, irq_oe;
  logic [8:0]  ev;
  logic [1:0]  bd = 2'h0;
  fcs_op_t     op_kind_i;
  logic [2:0]  lat;
  logic [5:0]  words;
  int          fails, check_count, cyc;

  fcs_regs u_dut (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .warm_reset_i(warm_reset_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .op_start_i(ev[8]),
    .op_kind_i(op_kind_i), .op_done_i(ev[7]), .op_fail_i(ev[6]), .op_lock_hit_i(ev[5]),
    .invalid_cmd_i(ev[4]), .erase_suspend_i(ev[3]), .erase_resume_i(ev[2]),
    .reset_op_start_i(ev[1]), .reset_op_done_i(ev[0]), .onetime_lock_i(onetime_lock_i),
    .irq_master_i(irq_master_i), .burst_data_next_i(bd[1]), .burst_data_after_next_i(bd[0]),
    .read_timing_select_o(rts), .burst_first_latency_o(lat), .burst_words_o(words),
    .ecc_bypass_o(ecc), .ready_pin_o(rdy), .ready_pin_oe_o(rdy_oe), .irq_pin_o(irq),
    .irq_pin_oe_o(irq_oe));
  fcs_host_model u_host (
    .ref_clk_i(ref_clk_i), .reg_rdata_i(reg_rdata_o), .reg_addr_o(reg_addr_i),
    .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

  // Clock at 25 MHz.
  initial ref_clk_i = 1'b0;
  always #20 ref_clk_i = ~ref_clk_i;

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // The whole run needs well under a thousand cycles; a hang is cut short here.
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      complete_run();
    end
  end

  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input logic [15:0] m);
    u_host.read(a, rd);
    `CHK("rdata", exp & m, rd & m)
  endtask
  // Engine event pulses last exactly one cycle.
  task automatic fire(input logic [8:0] v);
    @(posedge ref_clk_i);
    ev <= v;
    @(posedge ref_clk_i);
    ev <= 9'h000;
  endtask
  task automatic cold();
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
  endtask

  initial begin
    reset_n_i = 1'b0; warm_reset_i = 1'b0; onetime_lock_i = 1'b0; irq_master_i = 1'b1;
    ev = 9'h000; op_kind_i = FCS_OP_LOAD; fails = 0; check_count = 0; cyc = 0;
    cold();
    // reset values, writes to fixed places refused.
    rd_chk(CFG, FCS_CONFIG_RESET, 16'hffff);
    `CHK("oe", 2'b00, {rdy_oe, irq_oe})
    `CHK("latency", FCS_LATENCY_RESET_CODE, lat)
    `CHK("words", FCS_WORDS_CONT, words)
    `CHK("mode", 1'b0, rts)
    `CHK("ecc", 1'b0, ecc)
    u_host.write(ST, 16'hffff);
    u_host.write(FCS_ADDR_CONFIG_SPARE, 16'hffff);
    u_host.write(16'h1234, 16'hffff);
    rd_chk(ST, FCS_STATUS_RESET, 16'hffff);
    rd_chk(CFG, FCS_CONFIG_RESET, 16'hffff);
    u_host.write(CFG, 16'hb72f);
    rd_chk(CFG, 16'hb720, 16'hffff);
    `CHK("mode", 1'b1, rts)
    `CHK("ecc", 1'b1, ecc)
    u_host.write(CFG, 16'h0860);
    rd_chk(CFG, 16'h3660, 16'hffff);
    for (int i = 0; i < 5; i++) begin
      cw = {1'b0, 3'(i + 3), 3'(i % 4), 9'h0c0};
      u_host.write(CFG, cw);
      rd_chk(CFG, cw, 16'hffff);
      `CHK("latency", 3'(i + 3), lat)
      `CHK("words", WORDS[i % 4], words)
    end
    for (int i = 0; i < 8; i++) begin
      cw = {8'h40, 2'(i), 6'h20};
      irq_master_i <= i[2];
      u_host.write(CFG, cw);
      u_host.read(CFG, rd);
      `CHK("oe", 2'b11, {rdy_oe, irq_oe})
      `CHK("ready", cw[7], rdy)
      `CHK("irq", i[2] ~^ cw[6], irq)
    end
    u_host.write(CFG, 16'h40e0);
    op_kind_i <= FCS_OP_PROG;
    fire(START);
    rd_chk(ST, 16'h9000, 16'hffff);
    `CHK("ready", 1'b0, rdy)
    fire(DONE);
    rd_chk(ST, 16'h0000, 16'hffff);
    `CHK("ready", 1'b1, rdy)
    // warm reset keeps the enable, a zero write clears it.
    u_host.write(CFG, 16'hb72f);
    @(posedge ref_clk_i);
    warm_reset_i <= 1'b1;
    @(posedge ref_clk_i);
    warm_reset_i <= 1'b0;
    rd_chk(CFG, 16'h40e0, 16'hffff);
    u_host.write(CFG, 16'h40c0);
    u_host.read(CFG, rd);
    `CHK("oe", 2'b00, {rdy_oe, irq_oe})
    for (int i = 0; i < 4; i++) begin
      bd <= 2'(i);
      u_host.write(CFG, {11'h607, i[1], 4'h0});
      u_host.read(CFG, rd);
      `CHK("ready", bd[i[1]], rdy)
    end
    // load, program and erase through pass, fail and lock.
    for (int k = 0; k < 3; k++) begin
      sb = 16'h2000 >> k;
      op_kind_i <= fcs_op_t'(k);
      fire(START);
      rd_chk(ST, 16'h8000 | sb, 16'hffff);
      fire(DONE | FAIL);
      rd_chk(ST, 16'h0400 | sb, 16'hffff);
      fire(START);
      fire(DONE | FAIL | LOCK);
      rd_chk(ST, 16'h4400 | sb, 16'hffff);
      fire(START);
      fire(DONE);
      rd_chk(ST, 16'h0000, 16'hffff);
    end
    fire(INV);
    rd_chk(ST, 16'h0400, 16'hffff);
    op_kind_i <= FCS_OP_LOAD;
    fire(START);
    fire(RST);
    rd_chk(ST, 16'h2480, 16'h2480);
    fire(RSTD);
    rd_chk(ST, 16'h0000, 16'h0080);
    op_kind_i <= FCS_OP_ERASE;
    fire(START);
    fire(SUSP | DONE);
    rd_chk(ST, 16'h0a00, 16'h8e00);
    op_kind_i <= FCS_OP_PROG;
    fire(START);
    rd_chk(ST, 16'h9a00, 16'hfe00);
    fire(DONE | FAIL);
    rd_chk(ST, 16'h1e00, 16'h7e00);
    fire(RES);
    rd_chk(ST, 16'h0000, 16'h0200);
    // cold reset drops the enable and captures the lock.
    u_host.write(CFG, 16'h40e0);
    u_host.read(CFG, rd);
    onetime_lock_i <= 1'b1;
    cold();
    `CHK("oe", 2'b00, {rdy_oe, irq_oe})
    rd_chk(ST, 16'h0040, 16'hffff);
    rd_chk(CFG, FCS_CONFIG_RESET, 16'hffff);
    complete_run();
  end
endmodule // fcs_regs_tb
